// *** rtl/nv_config_reg.sv ***
/*
  Nonvolatile configuration register with its command engine and the
  working configuration loaded from it at every boot.
  Assumes a command source that issues one-cycle requests synchronous
  to core_clk, and a power-on pulse from the supply supervisor.
*/
`timescale 1ns/1ps
`include "nvcfg_cfg.svh"

module nv_config_reg (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  // Power-on event
  input  wire logic                 powerOn,
  // Command request
  input  wire logic                 cmdValid,
  input  wire nvcfg_pkg::cmd_op_t   cmdOp,
  input  wire logic [15:0]          cmdData,
  // Command answer
  output logic                      rspValid,
  output logic [15:0]               rspData,
  output logic                      cmdRejected,
  output logic                      writeDone,
  // Status
  output logic                      writeInProgress,
  output logic                      booting,
  // Working configuration and stored word
  output nvcfg_pkg::work_cfg_t      workCfg,
  output logic [15:0]               storedWord
);
  import nvcfg_pkg::*;

  typedef enum logic [2:0] {
    ST_BOOT = 3'b001,
    ST_IDLE = 3'b010,
    ST_PROG = 3'b100
  } state_t;

  localparam logic [`NVCFG_CNT_W-1:0] PROG_LAST =
    `NVCFG_CNT_W'(`NVCFG_PROG_CYCLES - 1);

  state_t                   state_ff;
  state_t                   nxt_state;
  logic [15:0]              nvWord_ff;
  logic [15:0]              pendWord_ff;
  logic [`NVCFG_CNT_W-1:0]  progCnt_ff;
  work_cfg_t                workCfg_ff;
  work_cfg_t                decoded;
  logic                     rspValid_ff;
  logic [15:0]              rspData_ff;
  logic                     cmdRejected_ff;
  logic                     writeDone_ff;
  logic                     bootReq_ff;
  logic                     progEnd;
  logic                     acceptWrite;
  logic                     acceptRead;
  logic                     acceptStat;
  logic                     badCmd;
  logic                     bootDue;

  nvcfg_decode u_decode (
    .word (nvWord_ff),
    .cfg  (decoded)
  );

  // Pending power-on wins over a write, which is then refused, not lost
  assign bootDue     = powerOn || bootReq_ff;
  assign acceptRead  = cmdValid && (cmdOp == CMD_READ_NV);
  assign acceptStat  = cmdValid && (cmdOp == CMD_READ_STAT);
  assign acceptWrite = cmdValid && (cmdOp == CMD_WRITE_NV) && (state_ff == ST_IDLE) &&
                       !bootDue;
  assign badCmd      = cmdValid && ((cmdOp == CMD_NONE) ||
                       ((cmdOp == CMD_WRITE_NV) && !acceptWrite));
  assign progEnd     = (state_ff == ST_PROG) && (progCnt_ff == PROG_LAST);

  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_BOOT: begin
        nxt_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (bootDue) begin
          nxt_state = ST_BOOT;
        end else if (acceptWrite) begin
          nxt_state = ST_PROG;
        end
      end
      ST_PROG: begin
        if (progEnd) begin
          nxt_state = bootDue ? ST_BOOT : ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_BOOT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Power-on during programming waits for the commit
  // One in the boot cycle is served by that same load
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bootReq_ff <= 1'b0;
    end else if (powerOn && (state_ff == ST_PROG)) begin
      bootReq_ff <= 1'b1;
    end else if (state_ff == ST_BOOT) begin
      bootReq_ff <= 1'b0;
    end
  end

  // Program timer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      progCnt_ff <= '0;
    end else if (state_ff != ST_PROG) begin
      progCnt_ff <= '0;
    end else if (!progEnd) begin
      progCnt_ff <= progCnt_ff + `NVCFG_CNT_W'(1);
    end
  end

  // Word captured at write, committed at end of programming
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pendWord_ff <= `NVCFG_FACTORY_VALUE;
    end else if (acceptWrite) begin
      pendWord_ff <= cmdData;
    end
  end

  // Stored word, all ones from the factory
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      nvWord_ff <= `NVCFG_FACTORY_VALUE;
    end else if (progEnd) begin
      nvWord_ff <= pendWord_ff;
    end
  end

  // Working configuration changes only on a boot load
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      workCfg_ff.dummyCycles        <= `NVCFG_DUMMY_DEFAULT;
      workCfg_ff.dummyDefault       <= 1'b1;
      workCfg_ff.executeInPlaceMode <= EXEC_OFF;
      workCfg_ff.executeInPlaceOn   <= 1'b0;
      workCfg_ff.drvStrength        <= `NVCFG_DRV_DEFAULT;
      workCfg_ff.holdResetEn        <= 1'b1;
      workCfg_ff.protocol           <= PROTO_EXT;
    end else if (state_ff == ST_BOOT) begin
      workCfg_ff <= decoded;
    end
  end

  // Read answers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rspValid_ff <= 1'b0;
      rspData_ff  <= 16'h0000;
    end else begin
      rspValid_ff <= acceptRead || acceptStat;
      if (acceptRead) begin
        rspData_ff <= nvWord_ff;
      end else if (acceptStat) begin
        rspData_ff <= {15'h0000, (state_ff == ST_PROG)};
      end
    end
  end

  // Event pulses
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmdRejected_ff <= 1'b0;
      writeDone_ff   <= 1'b0;
    end else begin
      cmdRejected_ff <= badCmd;
      writeDone_ff   <= progEnd;
    end
  end

  assign rspValid        = rspValid_ff;
  assign rspData         = rspData_ff;
  assign cmdRejected     = cmdRejected_ff;
  assign writeDone       = writeDone_ff;
  assign writeInProgress = (state_ff == ST_PROG);
  assign booting         = (state_ff == ST_BOOT);
  assign workCfg         = workCfg_ff;
  assign storedWord      = nvWord_ff;

endmodule

// *** inc/nvcfg_cfg.svh ***
/*
  Constants for the nonvolatile configuration register block: field
  positions, reset values, decode defaults and program timing.
  Assumes a 20 MHz core clock and inclusion by bare name.
*/
// Overview of operation
// - Bits 15:12 give fast-read dummy cycles
// - Codes 0000 and 1111 both mean default
// - Bits 11:9 pick execute-in-place mode at boot
// - Bit 4 high enables hold/reset pin
// - Bit 3 low selects quad protocol
// - Bit 2 low selects dual protocol
// - Both low gives quad, quad wins
// - Settings take effect only after power-on
// - Stored value starts as all ones
// - Access only through read/write register commands; the storedWord port also shows the stored word directly
// - Boot copies stored word into working config
// - Write-in-progress shows busy during programming
`ifndef NVCFG_CFG_SVH
`define NVCFG_CFG_SVH

// Field positions
`define NVCFG_DUMMY_HI      15
`define NVCFG_DUMMY_LO      12
`define NVCFG_EXEC_HI       11
`define NVCFG_EXEC_LO       9
`define NVCFG_DRV_HI        8
`define NVCFG_DRV_LO        6
`define NVCFG_HOLD_BIT      4
`define NVCFG_QUAD_BIT      3
`define NVCFG_DUAL_BIT      2

// Reset and decode values
`define NVCFG_FACTORY_VALUE 16'hffff
`define NVCFG_DUMMY_DEF_A   4'h0
`define NVCFG_DUMMY_DEF_B   4'hf
`define NVCFG_DUMMY_DEFAULT 4'ha
`define NVCFG_DRV_DEFAULT   3'h7
`define NVCFG_DRV_RSV_A     3'h0
`define NVCFG_DRV_RSV_B     3'h4

// Program timing
`define NVCFG_CLK_PERIOD_NS 50
`define NVCFG_PROG_TIME_NS  100000
`define NVCFG_PROG_CYCLES   ((`NVCFG_PROG_TIME_NS + `NVCFG_CLK_PERIOD_NS - 1) / `NVCFG_CLK_PERIOD_NS)
`define NVCFG_CNT_W         12

`endif

// *** inc/nvcfg_pkg.sv ***
/*
  Types for the nonvolatile configuration register block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package nvcfg_pkg;

  typedef enum logic [1:0] {
    CMD_READ_NV   = 2'h0,
    CMD_WRITE_NV  = 2'h1,
    CMD_READ_STAT = 2'h2,
    CMD_NONE      = 2'h3
  } cmd_op_t;

  typedef enum logic [2:0] {
    EXEC_FAST     = 3'h0,
    EXEC_DUAL_OUT = 3'h1,
    EXEC_DUAL_IO  = 3'h2,
    EXEC_QUAD_OUT = 3'h3,
    EXEC_QUAD_IO  = 3'h4,
    EXEC_RSV_A    = 3'h5,
    EXEC_RSV_B    = 3'h6,
    EXEC_OFF      = 3'h7
  } exec_mode_t;

  typedef enum logic [1:0] {
    PROTO_EXT  = 2'h0,
    PROTO_DUAL = 2'h1,
    PROTO_QUAD = 2'h2
  } proto_t;

  typedef struct packed {
    logic [3:0] dummyCycles;
    logic       dummyDefault;
    exec_mode_t executeInPlaceMode;
    logic       executeInPlaceOn;
    logic [2:0] drvStrength;
    logic       holdResetEn;
    proto_t     protocol;
  } work_cfg_t;

endpackage

// *** rtl/nvcfg_decode.sv ***
/*
  Combinational decode of the stored configuration word into the
  working configuration fields.
  Assumes the caller registers the result where it is used.
*/
`timescale 1ns/1ps
`include "nvcfg_cfg.svh"

module nvcfg_decode (
  // Stored word
  input  wire logic [15:0]           word,
  // Decoded fields
  output nvcfg_pkg::work_cfg_t       cfg
);
  import nvcfg_pkg::*;

  logic [3:0] dummyCode;
  logic [2:0] execCode;
  logic [2:0] drvCode;

  always_comb begin
    dummyCode = word[`NVCFG_DUMMY_HI:`NVCFG_DUMMY_LO];
    execCode  = word[`NVCFG_EXEC_HI:`NVCFG_EXEC_LO];
    drvCode   = word[`NVCFG_DRV_HI:`NVCFG_DRV_LO];
    cfg       = '0;
    // Default code pair collapses onto one count
    if (dummyCode == `NVCFG_DUMMY_DEF_A || dummyCode == `NVCFG_DUMMY_DEF_B) begin
      cfg.dummyCycles  = `NVCFG_DUMMY_DEFAULT;
      cfg.dummyDefault = 1'b1;
    end else begin
      cfg.dummyCycles  = dummyCode;
      cfg.dummyDefault = 1'b0;
    end
    // Reserved modes behave as disabled
    unique case (execCode)
      EXEC_FAST, EXEC_DUAL_OUT, EXEC_DUAL_IO, EXEC_QUAD_OUT, EXEC_QUAD_IO: begin
        cfg.executeInPlaceMode = exec_mode_t'(execCode);
        cfg.executeInPlaceOn   = 1'b1;
      end
      default: begin
        cfg.executeInPlaceMode = EXEC_OFF;
        cfg.executeInPlaceOn   = 1'b0;
      end
    endcase
    // Reserved strengths fall back to the default drive
    if (drvCode == `NVCFG_DRV_RSV_A || drvCode == `NVCFG_DRV_RSV_B) begin
      cfg.drvStrength = `NVCFG_DRV_DEFAULT;
    end else begin
      cfg.drvStrength = drvCode;
    end
    cfg.holdResetEn = word[`NVCFG_HOLD_BIT];
    if (!word[`NVCFG_QUAD_BIT]) begin
      cfg.protocol = PROTO_QUAD;
    end else if (!word[`NVCFG_DUAL_BIT]) begin
      cfg.protocol = PROTO_DUAL;
    end else begin
      cfg.protocol = PROTO_EXT;
    end
    // Bits 5 and 1:0 are never looked at
  end

endmodule

// *** dv/nvcfg_chk.sv ***
/* Port checker for nv_config_reg. Assumes the config header on the include path. */
`timescale 1ns/1ps
`include "nvcfg_cfg.svh"
module nvcfg_chk
  import nvcfg_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Requests
  input wire logic powerOn,
  input wire logic cmdValid,
  input wire nvcfg_pkg::cmd_op_t cmdOp,
  input wire logic [15:0] cmdData,
  // Answers and state
  input wire logic rspValid,
  input wire logic [15:0] rspData,
  input wire logic cmdRejected,
  input wire logic writeDone,
  input wire logic writeInProgress,
  input wire logic booting,
  input wire nvcfg_pkg::work_cfg_t workCfg,
  input wire logic [15:0] storedWord
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [11:0] wipLen_ff;
  logic [15:0] pend_ff;
  logic wrOk;
  assign wrOk = cmdValid && cmdOp == CMD_WRITE_NV && !writeInProgress && !booting && !powerOn;
  always_ff @(posedge core_clk or posedge rst)
    if (rst) wipLen_ff <= '0;
    else wipLen_ff <= writeInProgress ? wipLen_ff + 12'h1 : '0;
  always_ff @(posedge core_clk)
    if (wrOk) pend_ff <= cmdData;
  sequence progEnd;
    writeDone && wipLen_ff == `NVCFG_PROG_CYCLES;
  endsequence
  chk_read_answer: assert property (cmdValid && cmdOp == CMD_READ_NV |=> rspValid && rspData == $past(storedWord)) else $error("read answer wrong");
  chk_status_busy: assert property (cmdValid && cmdOp == CMD_READ_STAT |=> rspValid && rspData == {15'h0, $past(writeInProgress)}) else $error("status answer wrong");
  chk_write_start: assert property (wrOk |=> writeInProgress) else $error("busy not raised");
  chk_prog_end: assert property ($fell(writeInProgress) |-> progEnd) else $error("program length wrong");
  chk_store_commit: assert property (writeDone |-> storedWord == pend_ff) else $error("stored word wrong");
  chk_write_refuse: assert property (cmdValid && cmdOp == CMD_WRITE_NV && !wrOk |=> cmdRejected) else $error("write not refused");
  chk_cfg_frozen: assert property (!booting |=> $stable(workCfg)) else $error("config moved outside boot");
  chk_boot_quad: assert property (booting && !storedWord[3] |=> workCfg.protocol == PROTO_QUAD) else $error("quad not chosen");
  chk_boot_hold: assert property (booting |=> workCfg.holdResetEn == $past(storedWord[4])) else $error("hold bit not loaded");
  chk_boot_entry: assert property (powerOn && !writeInProgress && !booting |=> booting) else $error("boot not entered");
endmodule
bind nv_config_reg nvcfg_chk chk (.*);

// *** dv/nvcfg_host.sv ***
/* Host model issuing one command per call. Assumes a free-running core_clk. */
`timescale 1ns/1ps
module nvcfg_host
  import nvcfg_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Command request
  output nvcfg_pkg::cmd_op_t cmdOp,
  output logic cmdValid,
  output logic [15:0] cmdData
);
  initial begin
    cmdValid = 1'b0;
    cmdOp = CMD_NONE;
    cmdData = 16'h0;
  end
  task automatic issue(input cmd_op_t op, input logic [15:0] d);
    @(negedge core_clk);
    cmdValid = 1'b1;
    cmdOp = op;
    cmdData = d;
    @(negedge core_clk);
    cmdValid = 1'b0;
    cmdOp = CMD_NONE;
    cmdData = ~d;
  endtask
endmodule

// *** dv/tb.sv ***
/* Top bench for nv_config_reg. Assumes host model and checker files. */
`timescale 1ns/1ps
module tb;
  import nvcfg_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic powerOn = 1'b0;
  logic cmdValid, rspValid, cmdRejected, writeDone, writeInProgress, booting;
  cmd_op_t cmdOp;
  logic [15:0] cmdData, rspData, storedWord, w;
  logic [15:0] last = 16'hffff;
  work_cfg_t workCfg;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int k;
  always #25 core_clk = ~core_clk;
  nvcfg_host host (.*);
  nv_config_reg uut (.*);
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic chkCfg(input work_cfg_t e);
    n_checks++;
    if (workCfg !== e) begin
      err_total++;
      $display("BAD workCfg exp %h got %h", e, workCfg);
    end
  endtask
  function automatic work_cfg_t exp(input logic [15:0] x);
    work_cfg_t e;
    e.dummyDefault = x[15:12] == 4'h0 || x[15:12] == 4'hf;
    e.dummyCycles = e.dummyDefault ? 4'ha : x[15:12];
    e.executeInPlaceMode = exec_mode_t'(x[11:9] inside {3'h5, 3'h6} ? 3'h7 : x[11:9]);
    e.executeInPlaceOn = x[11:9] < 3'h5;
    e.drvStrength = x[8:6] inside {3'h0, 3'h4} ? 3'h7 : x[8:6];
    e.holdResetEn = x[4];
    e.protocol = !x[3] ? PROTO_QUAD : !x[2] ? PROTO_DUAL : PROTO_EXT;
    return e;
  endfunction
  task automatic results;
    if (err_total == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      results();
    end
  end
  initial begin
    repeat (3) @(negedge core_clk);
    fork
      host.issue(CMD_WRITE_NV, 16'h0);
      begin
        @(negedge core_clk);
        rst = 1'b0;
      end
    join
    chk("bootRefuse", 16'h1, 16'(cmdRejected));
    chk("factory", 16'hffff, storedWord);
    chkCfg(exp(16'hffff));
    host.issue(CMD_NONE, 16'h0);
    chk("badOp", 16'h1, 16'(cmdRejected));
    for (int i = 0; i < 8; i++) begin
      // Dummy codes step by three and wrap, hitting both default codes 0 and 15
      w = {4'(i * 3), 3'(i), 3'(i), 6'(i * 11)};
      host.issue(CMD_WRITE_NV, w);
      host.issue(CMD_READ_STAT, 16'h0);
      chk("wip", 16'h1, rspData);
      host.issue(CMD_WRITE_NV, ~w);
      chk("busyRefuse", 16'h1, 16'(cmdRejected));
      host.issue(CMD_READ_NV, 16'h0);
      chk("oldWord", last, rspData);
      k = 0;
      while (writeDone !== 1'b1 && k < 2100) begin
        @(negedge core_clk);
        k++;
      end
      chk("done", 16'h1, 16'(writeDone));
      host.issue(CMD_READ_STAT, 16'h0);
      chk("idle", 16'h0, rspData);
      host.issue(CMD_READ_NV, 16'h0);
      chk("newWord", w, rspData);
      chkCfg(exp(last));
      @(negedge core_clk);
      powerOn = 1'b1;
      @(negedge core_clk);
      powerOn = 1'b0;
      chk("booting", 16'h1, 16'(booting));
      @(negedge core_clk);
      chkCfg(exp(w));
      last = w;
    end
    @(negedge core_clk);
    rst = 1'b1;
    @(negedge core_clk);
    chk("reReset", 16'hffff, storedWord);
    chkCfg(exp(16'hffff));
    rst = 1'b0;
    results();
  end
endmodule
